// ### sic_pkg.sv
// constants, field layout and register map of the IF control word block
package sic_pkg;
    // serial word layout
    localparam int WORD_W        = 22;
    localparam int ADDR_LSB      = 0;
    localparam int ADDR_MSB      = 1;
    localparam int PUMP_LSB      = 2;
    localparam int PUMP_MSB      = 3;
    localparam int TEST_LSB      = 4;
    localparam int TEST_MSB      = 6;
    localparam int REFDIV_LSB    = 7;
    localparam int REFDIV_MSB    = 19;
    localparam int FRAC_LSB      = 20;
    localparam int FRAC_MSB      = 21;
    localparam int REFDIV_W      = 13;
    localparam int BITCNT_W      = 5;

    // address codes of the two serial words decoded here
    localparam logic [1:0] ADDR_WORD0 = 2'h0;
    localparam logic [1:0] ADDR_WORD1 = 2'h1;

    // fractional-n mode codes
    localparam logic [1:0] FRAC_DITHER   = 2'h2;
    localparam logic [1:0] FRAC_NODITHER = 2'h3;

    // pump current per code, in microamps
    localparam logic [10:0] PUMP_UA_0 = 11'h190; // 0.4 mA
    localparam logic [10:0] PUMP_UA_1 = 11'h320; // 0.8 mA
    localparam logic [10:0] PUMP_UA_2 = 11'h4b0; // 1.2 mA
    localparam logic [10:0] PUMP_UA_3 = 11'h640; // 1.6 mA

    // reset values of the decoded word 00 and the raw word 01
    localparam logic [WORD_W-1:0] WORD0_RESET = 22'h200000;
    localparam logic [WORD_W-1:0] WORD1_RESET = 22'h000001;

    // apb register indices; byte address is four times the index
    localparam int          APB_AW     = 12;
    localparam logic [9:0]  IDX_WORD0  = 10'h000;
    localparam logic [9:0]  IDX_WORD1  = 10'h001;
    localparam logic [9:0]  IDX_CTRL   = 10'h002;
    localparam logic [9:0]  IDX_STATUS = 10'h003;

    // control and status bit positions
    localparam int CTRL_RX_EN    = 0;
    localparam int STAT_RSV_MODE = 0;
    localparam int STAT_LEN_ERR  = 1;
    localparam int STAT_CNT_LSB  = 8;
    localparam int STAT_CNT_MSB  = 15;
    localparam logic CTRL_RX_EN_RESET = 1'b1;
endpackage

// ### sic_word_if.sv
// carrier of a received serial word from the shifter to the register bank
`timescale 1ns/10ps
interface sic_word_if;
    import sic_pkg::*;
    logic              valid;   // one-cycle pulse: le rose after 22 bits
    logic [WORD_W-1:0] word;    // word, msb first on the wire
    logic              len_err; // one-cycle pulse: le rose after wrong count
    modport src (output valid, output word, output len_err);
    modport dst (input valid, input word, input len_err);
endinterface

// ### sic_serial_rx.sv
// three-wire serial receiver, pins sampled on the system clock
`timescale 1ns/10ps
module sic_serial_rx
    import sic_pkg::*;
(
    input  wire logic  i_clock,
    input  wire logic  i_reset_n,
    input  wire logic  i_enable,     // from control register
    input  wire logic  i_sclk,       // serial clock pin
    input  wire logic  i_sdata,      // serial data pin
    input  wire logic  i_latch,      // latch enable pin
    sic_word_if.src    word_out
);
    // two-stage synchronisers plus a third stage for edge finding
    logic [1:0]        sclk_sync_reg;
    logic [1:0]        data_sync_reg;
    logic [1:0]        le_sync_reg;
    logic              sclk_last_reg;
    logic              le_last_reg;
    logic [WORD_W-1:0] shift_reg;
    logic [BITCNT_W-1:0] count_reg;
    logic              sclk_rise;
    logic              le_rise;

    // first stage feeds only the second
    always_ff @(posedge i_clock or negedge i_reset_n) begin
        if (!i_reset_n) begin
            sclk_sync_reg <= 2'h0;
            data_sync_reg <= 2'h0;
            // latch idles high: start high so reset makes no false rise
            le_sync_reg   <= 2'h3;
            sclk_last_reg <= 1'b0;
            le_last_reg   <= 1'b1;
        end else begin
            sclk_sync_reg <= {sclk_sync_reg[0], i_sclk};
            data_sync_reg <= {data_sync_reg[0], i_sdata};
            le_sync_reg   <= {le_sync_reg[0], i_latch};
            sclk_last_reg <= sclk_sync_reg[1];
            le_last_reg   <= le_sync_reg[1];
        end
    end

    // edges seen on the synchronised levels only
    assign sclk_rise = sclk_sync_reg[1] & ~sclk_last_reg;
    assign le_rise   = le_sync_reg[1] & ~le_last_reg;

    // data and clock share sync depth, so they stay aligned; data must
    // be stable for one system clock around the serial rising edge
    always_ff @(posedge i_clock or negedge i_reset_n) begin
        if (!i_reset_n) begin
            shift_reg <= '0;
            count_reg <= '0;
        end else if (le_rise) begin
            count_reg <= '0;
        end else if (sclk_rise && !le_sync_reg[1] && i_enable) begin
            // msb first: new bit enters at the bottom
            shift_reg <= {shift_reg[WORD_W-2:0], data_sync_reg[1]};
            if (count_reg != '1) begin
                count_reg <= count_reg + 1'b1; // saturates, never wraps
            end
        end
    end

    // hand word over on latch edge; wrong length is reported, not used
    always_ff @(posedge i_clock or negedge i_reset_n) begin
        if (!i_reset_n) begin
            word_out.valid   <= 1'b0;
            word_out.len_err <= 1'b0;
            word_out.word    <= '0;
        end else begin
            word_out.valid   <= le_rise && i_enable &&
                                (count_reg == BITCNT_W'(WORD_W));
            word_out.len_err <= le_rise && i_enable &&
                                (count_reg != BITCNT_W'(WORD_W));
            if (le_rise) begin
                word_out.word <= shift_reg;
            end
        end
    end
endmodule // sic_serial_rx

// ### sic_ctrl_word.sv
// top: serial control word decode with apb register access
`timescale 1ns/10ps
module sic_ctrl_word
    import sic_pkg::*;
(
    input  wire logic                i_clock,
    input  wire logic                i_reset_n,
    // three-wire serial link
    input  wire logic                i_sclk,
    input  wire logic                i_sdata,
    input  wire logic                i_latch,
    // apb slave
    input  wire logic                i_psel,
    input  wire logic                i_penable,
    input  wire logic                i_pwrite,
    input  wire logic [APB_AW-1:0]   i_paddr,
    input  wire logic [31:0]         i_pwdata,
    output logic                     o_pready,
    output logic                     o_pslverr,
    output logic [31:0]              o_prdata,
    // decoded fields of the committed word
    output logic [1:0]               o_if_pump_current_sel,
    output logic [10:0]              o_if_pump_current_ua,
    output logic [2:0]               o_test_mode_sel,
    output logic [REFDIV_W-1:0]      o_if_ref_divide_ratio,
    output logic [1:0]               o_frac_mode,
    output logic                     o_word0_update
);
    sic_word_if        rx_word ();     // shifter to bank
    logic              rx_en_reg;      // serial capture enable
    logic [WORD_W-1:0] word0_reg;      // committed word, address 00
    logic [WORD_W-1:0] word1_reg;      // raw word, address 01
    logic              rsv_mode_reg;   // sticky: reserved frac code seen
    logic              len_err_reg;    // sticky: latch after wrong count
    logic [7:0]        commit_cnt_reg; // commits of word 00, wraps
    logic [10:0]       pump_ua_reg;    // pump current in microamps
    logic              update_reg;     // pulse after word 00 commit
    // apb side
    logic [31:0]       prdata_reg;     // read data flop
    logic [31:0]       rd_next;        // read mux output
    logic [9:0]        idx;            // word index of paddr
    logic              mapped;         // aligned and decoded
    logic              wr_strobe;      // access phase write
    logic              clr_rsv;        // clear of status bit 0
    logic              clr_len;        // clear of status bit 1
    // serial side routing
    logic [1:0]        rx_addr;        // address bits of the word
    logic              word0_hit;      // commit to word 00
    logic              word1_hit;      // commit to word 01

    // serial receiver: it alone sees the pins, so all that follows
    // runs on synchronised pulses and needs no further care about
    // metastability
    sic_serial_rx u_rx (
        .i_clock   (i_clock),
        .i_reset_n (i_reset_n),
        .i_enable  (rx_en_reg),
        .i_sclk    (i_sclk),
        .i_sdata   (i_sdata),
        .i_latch   (i_latch),
        .word_out  (rx_word)
    );

    // route by address bits of the received word
    // words 10 and 11 belong to other blocks and are dropped here
    // without a flag; they are legal traffic on the shared link
    assign rx_addr   = rx_word.word[ADDR_MSB:ADDR_LSB];
    assign word0_hit = rx_word.valid && (rx_addr == ADDR_WORD0);
    assign word1_hit = rx_word.valid && (rx_addr == ADDR_WORD1);

    // word 00 holds all decoded fields; no commit, no change
    // a cut or disabled frame never raises a hit, so it cannot land
    // the fields move on the edge after the hit, with the pulse
    always_ff @(posedge i_clock or negedge i_reset_n) begin
        if (!i_reset_n) begin
            word0_reg <= WORD0_RESET;
        end else if (word0_hit) begin
            word0_reg <= rx_word.word;
        end
    end

    // word 01 kept raw for software; its fields live elsewhere
    // reset value carries address 01 so a read shows a well formed word
    always_ff @(posedge i_clock or negedge i_reset_n) begin
        if (!i_reset_n) begin
            word1_reg <= WORD1_RESET;
        end else if (word1_hit) begin
            word1_reg <= rx_word.word;
        end
    end

    // field decode straight from the committed word
    // plain slices of a flop, so the outputs never glitch
    // the test-mode code is passed on as is; its meaning belongs to
    // the analog test logic downstream
    assign o_if_pump_current_sel = word0_reg[PUMP_MSB:PUMP_LSB];
    assign o_test_mode_sel       = word0_reg[TEST_MSB:TEST_LSB];
    assign o_if_ref_divide_ratio = word0_reg[REFDIV_MSB:REFDIV_LSB];
    assign o_frac_mode           = word0_reg[FRAC_MSB:FRAC_LSB];
    assign o_if_pump_current_ua  = pump_ua_reg;
    assign o_word0_update        = update_reg;

    // pump current lookup, registered alongside the commit
    // the table reads the incoming word so current and code move
    // together; a lookup on word0_reg would lag by a cycle
    always_ff @(posedge i_clock or negedge i_reset_n) begin
        if (!i_reset_n) begin
            pump_ua_reg <= PUMP_UA_0;
        end else if (word0_hit) begin
            // all four codes are legal, so no default
            unique case (rx_word.word[PUMP_MSB:PUMP_LSB])
                2'h0: pump_ua_reg <= PUMP_UA_0;
                2'h1: pump_ua_reg <= PUMP_UA_1;
                2'h2: pump_ua_reg <= PUMP_UA_2;
                2'h3: pump_ua_reg <= PUMP_UA_3;
            endcase
        end
    end

    // commit pulse and counter
    // the pulse stands in the same cycle in which the fields change
    // count wraps at 255; software takes differences, not totals
    always_ff @(posedge i_clock or negedge i_reset_n) begin
        if (!i_reset_n) begin
            update_reg     <= 1'b0;
            commit_cnt_reg <= 8'h00;
        end else begin
            update_reg <= word0_hit;
            if (word0_hit) begin
                commit_cnt_reg <= commit_cnt_reg + 8'h01;
            end
        end
    end

    // apb decode: index is the word address, low two bits must be zero
    // only four word indices answer; any other index, or a byte address
    // that is not word aligned, is refused with an error and no effect
    // writes to the two serial words are ignored without error
    assign idx       = i_paddr[11:2];
    assign mapped    = (i_paddr[1:0] == 2'h0) &&
                       ((idx == IDX_WORD0) || (idx == IDX_WORD1) ||
                        (idx == IDX_CTRL) || (idx == IDX_STATUS));
    assign wr_strobe = i_psel && i_penable && i_pwrite && mapped;
    assign clr_rsv   = wr_strobe && (idx == IDX_STATUS) &&
                       i_pwdata[STAT_RSV_MODE];
    assign clr_len   = wr_strobe && (idx == IDX_STATUS) &&
                       i_pwdata[STAT_LEN_ERR];

    // zero wait states; unmapped address answers with an error
    // pready never drops, so every access ends in its first access
    // cycle; a slower register would need a real ready here
    assign o_pready  = 1'b1;
    assign o_pslverr = i_psel && i_penable && !mapped;
    assign o_prdata  = prdata_reg;

    // control register: software may stop serial capture
    // the pins stay synchronised while capture is off, so a frame
    // cut by a disable is cleared by the next latch rise
    always_ff @(posedge i_clock or negedge i_reset_n) begin
        if (!i_reset_n) begin
            rx_en_reg <= CTRL_RX_EN_RESET;
        end else if (wr_strobe && (idx == IDX_CTRL)) begin
            rx_en_reg <= i_pwdata[CTRL_RX_EN];
        end
    end

    // sticky flags, write one to clear; a new event beats the clear.
    // the host must avoid reserved codes; we keep them but flag them
    // a write of zero leaves a flag set, so a read-modify-write of
    // status cannot lose an event
    always_ff @(posedge i_clock or negedge i_reset_n) begin
        if (!i_reset_n) begin
            rsv_mode_reg <= 1'b0;
            len_err_reg  <= 1'b0;
        end else begin
            if (word0_hit && !rx_word.word[FRAC_MSB]) begin
                rsv_mode_reg <= 1'b1;
            end else if (clr_rsv) begin
                rsv_mode_reg <= 1'b0;
            end
            // length errors come straight from the receiver
            if (rx_word.len_err) begin
                len_err_reg <= 1'b1;
            end else if (clr_len) begin
                len_err_reg <= 1'b0;
            end
        end
    end

    // read mux, evaluated for the setup cycle address
    // upper bits of every word read as zero; unmapped indices and
    // misaligned addresses read as zero too
    always_comb begin
        rd_next = 32'h0000_0000;
        unique case (idx)
            IDX_WORD0: rd_next[WORD_W-1:0] = word0_reg;
            IDX_WORD1: rd_next[WORD_W-1:0] = word1_reg;
            IDX_CTRL:  rd_next[CTRL_RX_EN] = rx_en_reg;
            // status also carries the commit count for polling
            IDX_STATUS: begin
                rd_next[STAT_RSV_MODE] = rsv_mode_reg;
                rd_next[STAT_LEN_ERR]  = len_err_reg;
                rd_next[STAT_CNT_MSB:STAT_CNT_LSB] = commit_cnt_reg;
            end
            default: rd_next = 32'h0000_0000;
        endcase
        if (i_paddr[1:0] != 2'h0) begin
            rd_next = 32'h0000_0000; // misaligned reads give zero
        end
    end

    // read data captured in setup so it is a flop in the access phase
    // writes and idle cycles leave the last read data in place
    always_ff @(posedge i_clock or negedge i_reset_n) begin
        if (!i_reset_n) begin
            prdata_reg <= 32'h0000_0000;
        end else if (i_psel && !i_penable && !i_pwrite) begin
            prdata_reg <= rd_next;
        end
    end
endmodule // sic_ctrl_word

// ### sic_host_model.sv
// host model driving the three-wire serial link pins
`timescale 1ns/10ps
module sic_host_model (
    output logic o_sclk,  // serial clock, idle low
    output logic o_sdata, // serial data
    output logic o_latch  // latch enable, idle high
);
    // pins settle at time zero, latch parked high
    initial begin
        o_sclk = 1'b0;
        o_sdata = 1'b0;
        o_latch = 1'b1;
    end
    // one frame of n bits, msb first; ends on latch rise
    task automatic send(input logic [21:0] w, input int n);
        // start off the system clock edge so pins never race it
        #3;
        o_latch = 1'b0;
        #200;
        for (int k = n - 1; k >= 0; k--) begin
            o_sdata = w[k % 22]; // a 23rd bit repeats bit 0
            #40 o_sclk = 1'b1;
            #80 o_sclk = 1'b0;
            #40;
        end
        // released data line shows no stale value
        o_sdata = ~o_sdata;
        #40 o_latch = 1'b1;
    endtask
endmodule // sic_host_model

// ### sic_ctrl_word_sva.sv
// checker of the decoded control word outputs
`timescale 1ns/10ps
module sic_ctrl_word_sva (
    input wire logic        i_clock,
    input wire logic        i_reset_n,
    input wire logic        i_latch,
    input wire logic [1:0]  o_if_pump_current_sel,
    input wire logic [10:0] o_if_pump_current_ua,
    input wire logic [2:0]  o_test_mode_sel,
    input wire logic [12:0] o_if_ref_divide_ratio,
    input wire logic [1:0]  o_frac_mode,
    input wire logic        o_word0_update
);
    logic [19:0] fields; // all decoded fields, word bits 21:2
    assign fields = {o_frac_mode, o_if_ref_divide_ratio,
                     o_test_mode_sel, o_if_pump_current_sel};
    default clocking cb @(posedge i_clock); endclocking
    default disable iff (!i_reset_n);
    // current follows the code in 0.4 ma steps
    property p_pump_ua;
        o_if_pump_current_ua == 11'(400 * (o_if_pump_current_sel + 1));
    endproperty
    a_pump_ua: assert property (p_pump_ua)
        else $error("pump current does not match code");
    // a change of fields is announced in the same cycle
    property p_change_pulse;
        $changed(fields) |-> o_word0_update;
    endproperty
    a_change_pulse: assert property (p_change_pulse)
        else $error("field change without update pulse");
    // fields only move shortly after a latch rise
    property p_change_cause;
        $changed(fields) |-> $past(i_latch, 3) && !$past(i_latch, 7);
    endproperty
    a_change_cause: assert property (p_change_cause)
        else $error("fields changed without latch rise");
    // update pulse is tied to a latch rise
    property p_update_cause;
        o_word0_update |-> $past(i_latch, 4) && !$past(i_latch, 8);
    endproperty
    a_update_cause: assert property (p_update_cause)
        else $error("update pulse without latch rise");
    // mode holds while no frame is being latched
    property p_frac_hold;
        (!i_latch) [*8] |-> $stable(o_frac_mode);
    endproperty
    a_frac_hold: assert property (p_frac_hold)
        else $error("fractional mode moved while latch low");
    c_update: cover property (o_word0_update);
    c_nodither: cover property (o_word0_update && o_frac_mode == 2'h3);
    c_pump_max: cover property (o_if_pump_current_sel == 2'h3);
endmodule // sic_ctrl_word_sva
bind sic_ctrl_word sic_ctrl_word_sva sic_ctrl_word_sva_i (
    .i_clock(i_clock), .i_reset_n(i_reset_n), .i_latch(i_latch),
    .o_if_pump_current_sel(o_if_pump_current_sel),
    .o_if_pump_current_ua(o_if_pump_current_ua),
    .o_test_mode_sel(o_test_mode_sel),
    .o_if_ref_divide_ratio(o_if_ref_divide_ratio),
    .o_frac_mode(o_frac_mode), .o_word0_update(o_word0_update));

// ### sic_ctrl_word_bench.sv
// self-checking bench of the control word block
`timescale 1ns/10ps
module sic_ctrl_word_bench;
    import sic_pkg::*;
    logic i_clock, i_reset_n, sclk, sdata, latch; // clock, pins
    logic psel, penable, pwrite, pready, pslverr;   // apb strobes
    logic [11:0] paddr;                             // apb address
    logic [31:0] pwdata, prdata, rd;                // apb data
    logic err, upd;                                 // last error, pulse
    logic [1:0] sel, frac;                          // decoded codes
    logic [2:0] tst;                                // test mode
    logic [12:0] ratio;                             // divide ratio
    logic [10:0] ua;                                // pump current
    logic [21:0] exp_w, w;                          // model word, stimulus
    logic [15:0] lfsr;                              // random state
    int fail_count, n_compared, n_commit;           // counters
    sic_host_model sic_host_model_i (.o_sclk(sclk), .o_sdata(sdata),
        .o_latch(latch));
    sic_ctrl_word sic_ctrl_word_i (.i_clock(i_clock),
        .i_reset_n(i_reset_n), .i_sclk(sclk), .i_sdata(sdata),
        .i_latch(latch), .i_psel(psel), .i_penable(penable),
        .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata),
        .o_pready(pready), .o_pslverr(pslverr), .o_prdata(prdata),
        .o_if_pump_current_sel(sel), .o_if_pump_current_ua(ua),
        .o_test_mode_sel(tst), .o_if_ref_divide_ratio(ratio),
        .o_frac_mode(frac), .o_word0_update(upd));
    // 100 mhz clock
    initial begin
        i_clock = 1'b0;
        forever #5 i_clock = ~i_clock;
    end
    function automatic logic [15:0] next_rand(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction
    task automatic end_of_test();
        $display("compared %0d failed %0d", n_compared, fail_count);
        if (fail_count == 0 && n_compared > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] seen, exp);
        n_compared++;
        if (seen !== exp) begin
            fail_count++;
            $display("unexpected %s exp %h seen %h", nm, exp, seen);
        end
    endtask
    // one apb transfer; waits bounded for pready
    task automatic apb(input logic wr, input logic [11:0] a,
                       input logic [31:0] wd);
        int n;
        n = 0;
        {psel, penable, pwrite, paddr, pwdata} <= {2'b10, wr, a, wd};
        @(posedge i_clock);
        penable <= 1'b1;
        do begin
            @(posedge i_clock);
            n++;
        end while (pready !== 1'b1 && n < 50);
        rd = prdata;
        err = pslverr;
        if (pready !== 1'b1) begin
            fail_count++;
            end_of_test();
        end
        {psel, penable} <= 2'b00;
        @(posedge i_clock);
    endtask
    // counts pulses in the fixed answer window, then compares with model
    task automatic check_commit(input logic exp_upd);
        int pulses;
        pulses = 0;
        repeat (20) begin
            @(posedge i_clock);
            if (upd === 1'b1) pulses++;
        end
        chk("update", 32'(pulses), 32'(exp_upd));
        chk("fields", 32'({frac, ratio, tst, sel}), 32'(exp_w[21:2]));
        chk("pump_ua", 32'(ua), 32'(400 * (exp_w[3:2] + 1)));
        apb(1'b0, 12'h000, 32'h0);
        chk("word0", rd, 32'(exp_w));
        apb(1'b0, 12'h00c, 32'h0);
        chk("count", 32'(rd[15:8]), 32'(n_commit[7:0]));
    endtask
    // main sequence
    initial begin
        i_reset_n = 1'b0;
        {psel, penable, pwrite, paddr, pwdata} = '0;
        {fail_count, n_compared, n_commit} = '0;
        lfsr = 16'h003f;
        exp_w = WORD0_RESET;
        repeat (8) @(posedge i_clock);
        i_reset_n <= 1'b1;
        repeat (4) @(posedge i_clock);
        check_commit(1'b0);
        chk("status", 32'(rd[1:0]), 32'h0);
        // every pump code, both legal fractional codes
        for (int i = 0; i < 4; i++) begin
            lfsr = next_rand(lfsr);
            w = {2'(2 + i % 2), lfsr[12:0], lfsr[15:13], 2'(i), 2'h0};
            sic_host_model_i.send(w, 22);
            exp_w = w;
            n_commit++;
            check_commit(1'b1);
        end
        // address 01 goes to the next word only
        w = {lfsr, 6'h01};
        sic_host_model_i.send(w, 22);
        check_commit(1'b0);
        apb(1'b0, 12'h004, 32'h0);
        chk("word1", rd, 32'(w));
        // wrong length and disabled receiver commit nothing
        sic_host_model_i.send(22'h3ffffc, 23);
        check_commit(1'b0);
        chk("len_err", 32'(rd[1:0]), 32'h2);
        apb(1'b1, 12'h00c, 32'h2);
        apb(1'b0, 12'h00c, 32'h0);
        chk("len_clr", 32'(rd[1:0]), 32'h0);
        apb(1'b1, 12'h008, 32'h0);
        sic_host_model_i.send(22'h3ffffc, 22);
        check_commit(1'b0);
        apb(1'b1, 12'h008, 32'h1);
        apb(1'b0, 12'h008, 32'h0);
        chk("rx_en", rd, 32'h1);
        // unmapped address answers with an error
        apb(1'b0, 12'h010, 32'h0);
        chk("pslverr", 32'(err), 32'h1);
        end_of_test();
    end
endmodule // sic_ctrl_word_bench
